// >>> rtl/mpos_pkg.sv
// Function
// - Run mode has four values: single cycle, cyclic, terminal select, sequential; cyclic default.
// - Profile count from 1 to 16 sets how many profiles take part.
// - Every profile holds its own displacement, speed and ramp time.
// - Outside terminal select, profiles advance upward from 1 to the profile count.
// - Terminal select runs profile equal to the 4-bit selection value plus one.
// - A selection bit is 1 while its terminal is valid, else 0.
// - Resume method 0 continues with the profile after the interrupted one.
// - Resume method 1 restarts from profile 1 after a pause.
// - Control mode switch or on-the-fly change during a run counts as pause.
// - Enable falling from active to inactive also pauses the run.
// - A pause discards the remaining displacement of the running profile.
// - Terminal select pauses only on mode switch or fly change; resumes from inputs.
// - Time unit setting applies to ramp times and waiting times.
// - Ramp time means time between standstill and 1000 RPM either way.
// - Configured waiting time lies between one profile's end and the next start.
// - Sequential mode ignores time unit and inserts no waiting time.
// - Terminal select ignores time unit; host timing of selections sets intervals.
// - Displacement type picks relative to current position or absolute from home.
// - A negative actual displacement runs the motor in reverse.
// - Sequential with restart 0 runs profiles once, stops and holds motor locked.
// - Sequential with restart 1 to 16 cycles, later rounds start there.
// - A restart position above the profile count is forced to 0.
package mpos_pkg;

  localparam int unsigned CLK_HZ           = 100_000_000;
  localparam int unsigned WAIT_TICK_MS     = 1;
  localparam int unsigned WAIT_TICK_CYCLES = CLK_HZ / 1000 * WAIT_TICK_MS;
  localparam int unsigned MS_PER_S         = 1000;

  localparam logic [7:0] REG_CFG     = 8'h00;
  localparam logic [7:0] REG_COUNT   = 8'h04;
  localparam logic [7:0] REG_RESTART = 8'h08;
  localparam logic [7:0] REG_STATUS  = 8'h0C;
  localparam logic [7:0] REG_PSEL    = 8'h10;
  localparam logic [7:0] REG_PDISP   = 8'h14;
  localparam logic [7:0] REG_PSPEED  = 8'h18;
  localparam logic [7:0] REG_PACCEL  = 8'h1C;
  localparam logic [7:0] REG_PWAIT   = 8'h20;

  localparam int CFG_MODE_LSB   = 0;
  localparam int CFG_RESUME_BIT = 4;
  localparam int CFG_UNIT_BIT   = 5;
  localparam int CFG_DTYPE_BIT  = 6;
  localparam int STAT_STATE_LSB = 8;
  localparam int STAT_HOLD_BIT  = 16;

  localparam logic [4:0]  COUNT_RST   = 5'h01;
  localparam logic [4:0]  COUNT_MAX   = 5'h10;
  localparam logic [4:0]  RESTART_RST = 5'h00;
  localparam logic        RESUME_RST  = 1'h0;
  localparam logic        UNIT_RST    = 1'h0;
  localparam logic        DTYPE_RST   = 1'h0;
  localparam logic [31:0] DISP_RST    = 32'h0000_2710;
  localparam logic [12:0] SPEED_RST   = 13'h00C8;

  typedef enum logic [1:0] {
    MODE_SINGLE     = 2'h0,
    MODE_CYCLIC     = 2'h1,
    MODE_SELECT     = 2'h2,
    MODE_SEQUENTIAL = 2'h3
  } run_mode_e;

  localparam run_mode_e MODE_RST = MODE_CYCLIC;

  typedef enum logic [6:0] {
    S_IDLE  = 7'h01,
    S_LOAD  = 7'h02,
    S_ISSUE = 7'h04,
    S_MOVE  = 7'h08,
    S_WAIT  = 7'h10,
    S_PAUSE = 7'h20,
    S_DONE  = 7'h40
  } seq_state_e;

  typedef struct packed {
    logic signed [31:0] disp;
    logic        [12:0] speed;
    logic        [15:0] accel;
    logic        [13:0] wait_t;
  } profile_s;

  typedef struct packed {
    logic signed [32:0] delta;
    logic               reverse;
    logic        [12:0] speed;
    logic        [15:0] accel;
    logic               unit_s;
  } move_cmd_s;

endpackage

// >>> rtl/profile_store.sv
`timescale 1ns/1ps
`default_nettype none
module profile_store (
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                arst_n,
  // Write port
  input  wire logic                wr_en,
  input  wire logic [3:0]          wr_idx,
  input  wire logic [1:0]          wr_field,
  input  wire logic [31:0]         wr_data,
  // Read ports
  input  wire logic [3:0]          rd_idx_a,
  output var mpos_pkg::profile_s   prof_a,
  input  wire logic [3:0]          rd_idx_b,
  output var mpos_pkg::profile_s   prof_b
);
  import mpos_pkg::*;

  profile_s mem_ff [16];

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 16; i++) begin
        mem_ff[i] <= '{disp: DISP_RST, speed: SPEED_RST, accel: 16'h0000, wait_t: 14'h0000};
      end
    end else if (wr_en) begin
      // Each field written on its own keeps profiles independent
      case (wr_field)
        2'h0: mem_ff[wr_idx].disp <= wr_data;
        2'h1: mem_ff[wr_idx].speed <= wr_data[12:0];
        2'h2: mem_ff[wr_idx].accel <= wr_data[15:0];
        default: mem_ff[wr_idx].wait_t <= wr_data[13:0];
      endcase
    end
  end

  assign prof_a = mem_ff[rd_idx_a];
  assign prof_b = mem_ff[rd_idx_b];

endmodule
`default_nettype wire

// >>> rtl/wait_timer.sv
`timescale 1ns/1ps
`default_nettype none
module wait_timer #(
  parameter int unsigned TICK_CYCLES = mpos_pkg::WAIT_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        arst_n,
  // Control
  input  wire logic        load,
  input  wire logic [13:0] wait_t,
  input  wire logic        unit_s,
  output logic             busy
);
  import mpos_pkg::*;

  logic [23:0] ms_left_ff;
  logic [31:0] pre_ff;
  wire  [23:0] load_ms = unit_s ? 24'(wait_t * 24'(MS_PER_S)) : 24'(wait_t);
  wire         tick    = (pre_ff == 32'(TICK_CYCLES - 1));

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ms_left_ff <= 24'h000000;
      pre_ff     <= 32'h0000_0000;
    end else if (load) begin
      ms_left_ff <= load_ms;
      pre_ff     <= 32'h0000_0000;
    end else if (ms_left_ff != 24'h000000) begin
      pre_ff     <= tick ? 32'h0000_0000 : pre_ff + 32'h0000_0001;
      ms_left_ff <= tick ? ms_left_ff - 24'h000001 : ms_left_ff;
    end
  end

  assign busy = (ms_left_ff != 24'h000000);

endmodule
`default_nettype wire

// >>> rtl/multi_position_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module multi_position_sequencer #(
  parameter int unsigned TICK_MS_CYCLES = mpos_pkg::WAIT_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               arst_n,
  // Register port
  input  wire logic [7:0]         reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [31:0]             reg_rdata,
  // Terminal inputs
  input  wire logic [3:0]         select_bit,
  input  wire logic               multipos_enable,
  // Drive context
  input  wire logic               mode_switch,
  input  wire logic               fly_change_en,
  input  wire logic signed [31:0] motor_pos,
  // Motion generator
  output logic                    move_start,
  output var mpos_pkg::move_cmd_s move_cmd,
  output logic                    move_abort,
  input  wire logic               move_done,
  output logic                    motor_hold,
  output logic [4:0]              cur_profile
);
  import mpos_pkg::*;

  function automatic logic [4:0] sel_prof(input logic [3:0] sel);
    sel_prof = {1'b0, sel} + 5'h01;
  endfunction

  // Configuration registers
  run_mode_e  mode_ff;
  logic       resume_ff;
  logic       unit_ff;
  logic       dtype_ff;
  logic [4:0] count_ff;
  logic [4:0] restart_ff;
  logic [3:0] psel_ff;
  logic [31:0] rdata_ff;

  // Synchronisers and sequencer state
  logic [3:0] sel_m_ff;
  logic [3:0] sel_s_ff;
  logic       en_m_ff;
  logic       en_s_ff;
  logic       en_d_ff;
  seq_state_e state_ff;
  seq_state_e nxt_state;
  logic [4:0] cur_ff;
  logic [3:0] last_sel_ff;
  move_cmd_s  cmd_ff;

  profile_s   prof_a;
  profile_s   prof_b;
  logic       timer_busy;

  // Register decode
  wire wr_cfg     = reg_wr && (reg_addr == REG_CFG);
  wire wr_count   = reg_wr && (reg_addr == REG_COUNT);
  wire wr_restart = reg_wr && (reg_addr == REG_RESTART);
  wire wr_psel    = reg_wr && (reg_addr == REG_PSEL);
  wire wr_prof    = reg_wr && (reg_addr >= REG_PDISP) && (reg_addr <= REG_PWAIT)
                    && (reg_addr[1:0] == 2'h0);
  wire [1:0] wr_field = 2'(8'(reg_addr - REG_PDISP) >> 2);
  wire [4:0] wr_cnt   = (reg_wdata[4:0] == 5'h00) ? COUNT_RST :
                        (reg_wdata[31:0] > 32'(COUNT_MAX)) ? COUNT_MAX : reg_wdata[4:0];
  wire [4:0] wr_rst   = (reg_wdata[31:0] > 32'(COUNT_MAX)) ? COUNT_MAX : reg_wdata[4:0];

  wire [31:0] status_w = {15'h0000, (state_ff == S_DONE), 1'b0, 7'(state_ff), 3'h0, cur_ff};
  wire [31:0] cfg_w    = {25'h0000000, dtype_ff, unit_ff, resume_ff, 2'h0, 2'(mode_ff)};
  wire [31:0] rd_mux   =
    (reg_addr == REG_CFG)     ? cfg_w :
    (reg_addr == REG_COUNT)   ? {27'h0000000, count_ff} :
    (reg_addr == REG_RESTART) ? {27'h0000000, restart_ff} :
    (reg_addr == REG_STATUS)  ? status_w :
    (reg_addr == REG_PSEL)    ? {28'h0000000, psel_ff} :
    (reg_addr == REG_PDISP)   ? prof_b.disp :
    (reg_addr == REG_PSPEED)  ? {19'h00000, prof_b.speed} :
    (reg_addr == REG_PACCEL)  ? {16'h0000, prof_b.accel} :
    (reg_addr == REG_PWAIT)   ? {18'h00000, prof_b.wait_t} : 32'h0000_0000;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mode_ff   <= MODE_RST;
      resume_ff <= RESUME_RST;
      unit_ff   <= UNIT_RST;
      dtype_ff  <= DTYPE_RST;
      count_ff  <= COUNT_RST;
      psel_ff   <= 4'h0;
    end else begin
      if (wr_cfg) begin
        mode_ff   <= run_mode_e'(reg_wdata[CFG_MODE_LSB +: 2]);
        resume_ff <= reg_wdata[CFG_RESUME_BIT];
        unit_ff   <= reg_wdata[CFG_UNIT_BIT];
        dtype_ff  <= reg_wdata[CFG_DTYPE_BIT];
      end
      if (wr_count) begin
        count_ff <= wr_cnt;
      end
      if (wr_psel) begin
        psel_ff <= reg_wdata[3:0];
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      restart_ff <= RESTART_RST;
      rdata_ff   <= 32'h0000_0000;
    end else begin
      if (wr_restart) begin
        restart_ff <= wr_rst;
      end else if (restart_ff > count_ff) begin
        restart_ff <= 5'h00;
      end
      rdata_ff <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_ff;

  // Terminal inputs come from pins, so two flops before any use
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sel_m_ff <= 4'h0;
      sel_s_ff <= 4'h0;
      en_m_ff  <= 1'b0;
      en_s_ff  <= 1'b0;
      en_d_ff  <= 1'b0;
    end else begin
      sel_m_ff <= select_bit;
      sel_s_ff <= sel_m_ff;
      en_m_ff  <= multipos_enable;
      en_s_ff  <= en_m_ff;
      en_d_ff  <= en_s_ff;
    end
  end

  // Sequencing decisions
  wire is_select = (mode_ff == MODE_SELECT);
  wire is_seq    = (mode_ff == MODE_SEQUENTIAL);
  wire en_fall   = en_d_ff && !en_s_ff;
  wire pause_now = mode_switch || fly_change_en || (!is_select && en_fall);
  wire go_ok     = en_s_ff && !mode_switch && !fly_change_en;
  wire last      = (cur_ff >= count_ff);
  wire end_run   = last && ((mode_ff == MODE_SINGLE) || (is_seq && restart_ff == 5'h00));
  wire [4:0] step_prof  = cur_ff + 5'h01;
  wire [4:0] adv_prof   = !last ? step_prof :
                          is_seq ? restart_ff : 5'h01;
  wire [4:0] after_prof = last ? 5'h01 : step_prof;
  wire [4:0] resume_prof = is_select ? sel_prof(sel_s_ff) :
                           resume_ff ? 5'h01 : after_prof;
  wire [4:0] start_prof = is_select ? sel_prof(sel_s_ff) : 5'h01;
  // A repeated selection of the same profile is not seen as a new command
  wire wait_over = is_select ? (sel_s_ff != last_sel_ff) : !timer_busy;
  wire unit_eff  = unit_ff && !is_seq && !is_select;
  wire motion    = (state_ff == S_ISSUE) || (state_ff == S_MOVE);

  wire [4:0] nxt_cur =
    (state_ff == S_IDLE)  ? start_prof :
    (state_ff == S_PAUSE) ? resume_prof :
    is_select             ? sel_prof(sel_s_ff) : adv_prof;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      S_IDLE: begin
        if (go_ok) nxt_state = S_LOAD;
      end
      S_LOAD: begin
        nxt_state = pause_now ? S_PAUSE : S_ISSUE;
      end
      S_ISSUE: begin
        nxt_state = pause_now ? S_PAUSE : S_MOVE;
      end
      S_MOVE: begin
        if (pause_now) nxt_state = S_PAUSE;
        else if (move_done) begin
          if (is_select) nxt_state = S_WAIT;
          else if (end_run) nxt_state = S_DONE;
          else if (is_seq) nxt_state = S_LOAD;
          else nxt_state = S_WAIT;
        end
      end
      S_WAIT: begin
        if (pause_now) nxt_state = S_PAUSE;
        else if (wait_over) nxt_state = S_LOAD;
      end
      S_PAUSE: begin
        if (go_ok) nxt_state = S_LOAD;
      end
      S_DONE: begin
        if (!en_s_ff) nxt_state = S_IDLE;
      end
      default: nxt_state = S_IDLE;
    endcase
  end

  wire enter_load = (nxt_state == S_LOAD) && (state_ff != S_LOAD);
  wire timer_load = (state_ff == S_MOVE) && (nxt_state == S_WAIT);

  // Actual displacement: relative as stored, absolute measured from home
  wire signed [32:0] delta_w = dtype_ff ? (33'(prof_a.disp) - 33'(motor_pos))
                                        : 33'(prof_a.disp);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_ff    <= S_IDLE;
      cur_ff      <= 5'h01;
      last_sel_ff <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      if (enter_load) begin
        cur_ff      <= nxt_cur;
        last_sel_ff <= sel_s_ff;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cmd_ff <= '0;
    end else if (state_ff == S_LOAD) begin
      cmd_ff.delta   <= delta_w;
      cmd_ff.reverse <= delta_w[32];
      cmd_ff.speed   <= prof_a.speed;
      // Ramp is the time from standstill to 1000 RPM in the chosen unit
      cmd_ff.accel   <= prof_a.accel;
      cmd_ff.unit_s  <= unit_eff;
    end
  end

  profile_store u_store (
    .clock    (clock),
    .arst_n   (arst_n),
    .wr_en    (wr_prof),
    .wr_idx   (psel_ff),
    .wr_field (wr_field),
    .wr_data  (reg_wdata),
    .rd_idx_a (4'(cur_ff - 5'h01)),
    .prof_a   (prof_a),
    .rd_idx_b (psel_ff),
    .prof_b   (prof_b)
  );

  wait_timer #(
    .TICK_CYCLES (TICK_MS_CYCLES)
  ) u_timer (
    .clock  (clock),
    .arst_n (arst_n),
    .load   (timer_load),
    .wait_t (prof_a.wait_t),
    .unit_s (unit_eff),
    .busy   (timer_busy)
  );

  assign move_start  = (state_ff == S_ISSUE);
  assign move_cmd    = cmd_ff;
  assign move_abort  = motion && pause_now;
  assign motor_hold  = (state_ff == S_DONE);
  assign cur_profile = cur_ff;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  start_one_cycle_a: assert property (move_start |=> !move_start)
    else $error("move start longer than one cycle");
  restart_forced_a: assert property (
    (restart_ff > count_ff) && !wr_restart |=> restart_ff == 5'h00)
    else $error("restart position not forced to zero");
  seq_no_wait_a: assert property (
    (state_ff == S_MOVE) && move_done && !pause_now && is_seq && !end_run |=> ##1 move_start)
    else $error("sequential mode inserted a wait");
  select_pick_a: assert property (
    (state_ff == S_IDLE) && go_ok && is_select |=> cur_ff == sel_prof($past(sel_s_ff)))
    else $error("selected profile wrong");
  pause_abort_a: assert property (
    (state_ff == S_MOVE) && pause_now |-> move_abort ##1 (state_ff == S_PAUSE))
    else $error("pause did not abort motion");
  resume_first_a: assert property (
    (state_ff == S_PAUSE) && go_ok && resume_ff && !is_select |=> cur_ff == 5'h01)
    else $error("resume did not restart at profile one");
  cyclic_wrap_a: assert property (
    (state_ff == S_MOVE) && move_done && !pause_now && last
    && (mode_ff == MODE_CYCLIC) |=> !motor_hold)
    else $error("cyclic mode stopped at last profile");
  reverse_dir_a: assert property (
    (state_ff == S_LOAD) && !dtype_ff && prof_a.disp[31] |=> move_cmd.reverse)
    else $error("negative displacement not reversed");
  enable_pause_a: assert property (
    (state_ff == S_WAIT) && en_fall && !is_select |=> state_ff == S_PAUSE)
    else $error("enable fall did not pause");

  seq_restart_a: assert property (
    (state_ff == S_MOVE) && move_done && !pause_now && is_seq && last
    && (restart_ff != 5'h00) |=> cur_ff == $past(restart_ff))
    else $error("sequential round did not restart at set profile");

  run_stop_a: assert property (
    (state_ff == S_MOVE) && move_done && !pause_now && end_run |=> motor_hold)
    else $error("finished run did not hold the motor");

  resume_next_a: assert property (
    (state_ff == S_PAUSE) && go_ok && !resume_ff && !is_select
    |=> cur_ff == (($past(cur_ff) >= $past(count_ff)) ? 5'h01 : $past(cur_ff) + 5'h01))
    else $error("resume did not continue with next profile");

  select_resume_a: assert property (
    (state_ff == S_PAUSE) && go_ok && is_select |=> cur_ff == sel_prof($past(sel_s_ff)))
    else $error("select resume did not follow inputs");

  unit_ignored_a: assert property (
    (state_ff == S_LOAD) && (is_seq || is_select) |=> !move_cmd.unit_s)
    else $error("time unit used in sequential or select mode");

  abort_motion_a: assert property (
    move_abort |-> motion)
    else $error("abort outside of motion");

  ramp_copy_a: assert property (
    (state_ff == S_LOAD) |=> move_cmd.accel == $past(prof_a.accel))
    else $error("ramp time not taken from profile");

  speed_copy_a: assert property (
    (state_ff == S_LOAD) |=> move_cmd.speed == $past(prof_a.speed))
    else $error("speed not taken from profile");

  sign_dir_a: assert property (
    (state_ff == S_ISSUE) |-> move_cmd.reverse == move_cmd.delta[32])
    else $error("direction does not match displacement sign");

  // Read data must return to zero so stale words never look fresh
  rdata_idle_a: assert property (
    !reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data present without read");

endmodule
`default_nettype wire

// >>> verification/motion_model.sv
`timescale 1ns/1ps
`default_nettype none
module motion_model (
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                arst_n,
  // Sequencer side
  input  wire logic                move_start,
  input  wire mpos_pkg::move_cmd_s move_cmd,
  input  wire logic                move_abort,
  output logic                     move_done,
  output logic signed [31:0]       motor_pos,
  // Move length in cycles, 1 or more
  input  wire logic [7:0]          lat
);
  import mpos_pkg::*;
  logic [7:0] left_ff;
  logic       busy_ff;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      left_ff   <= 8'h00;
      busy_ff   <= 1'b0;
      move_done <= 1'b0;
      motor_pos <= 32'sh0;
    end else begin
      move_done <= 1'b0;
      if (move_abort) begin
        // Aborted moves leave the position where it was
        busy_ff <= 1'b0;
      end else if (move_start) begin
        busy_ff <= 1'b1;
        left_ff <= lat;
      end else if (busy_ff) begin
        left_ff <= left_ff - 8'h01;
        if (left_ff == 8'h01) begin
          busy_ff   <= 1'b0;
          move_done <= 1'b1;
          motor_pos <= motor_pos + move_cmd.delta[31:0];
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> verification/tb_multi_position_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_multi_position_sequencer;
  import mpos_pkg::*;
  localparam int TICK = 10;
  logic              clock, arst_n, reg_wr, reg_rd, multipos_enable, mode_switch, fly_change_en;
  logic [7:0]        reg_addr, lat;
  logic [31:0]       reg_wdata, reg_rdata;
  logic [3:0]        select_bit;
  logic signed [31:0] motor_pos;
  logic [4:0]        cur_profile;
  logic              move_start, move_abort, move_done, motor_hold;
  move_cmd_s         move_cmd;
  int                fail_count = 0, n_checks = 0, since_done = 0;

  multi_position_sequencer #(.TICK_MS_CYCLES(TICK)) u_multi_position_sequencer (
    .clock, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .select_bit,
    .multipos_enable, .mode_switch, .fly_change_en, .motor_pos, .move_start, .move_cmd,
    .move_abort, .move_done, .motor_hold, .cur_profile);
  motion_model u_motion_model (.clock, .arst_n, .move_start, .move_cmd, .move_abort,
    .move_done, .motor_pos, .lat);

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) since_done <= move_done ? 0 : since_done + 1;

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t ns: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, e);
  endtask
  // Looks in the current cycle first, so a one-cycle pulse is not missed
  task automatic wait_for(input int which, input int limit);
    for (int i = 0; i <= limit; i++) begin
      #1;
      if (which == 0 && move_start === 1'b1) return;
      if (which == 1 && move_abort === 1'b1) return;
      if (which == 2 && motor_hold === 1'b1) return;
      @(posedge clock);
    end
    fail_count++;
    $display("unexpected at %0t ns: wait %0h ran out", $time, which);
    give_verdict();
  endtask
  task automatic nxt(input int p, input int limit);
    @(posedge clock);
    wait_for(0, limit);
    check(cur_profile, p);
  endtask
  task automatic do_reset;
    @(posedge clock);
    arst_n          <= 1'b0;
    multipos_enable <= 1'b0;
    mode_switch     <= 1'b0;
    fly_change_en   <= 1'b0;
    select_bit      <= 4'h0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
  endtask
  task automatic set_prof(input int i, input logic [31:0] d, input logic [31:0] w);
    wr(REG_PSEL, i);
    wr(REG_PDISP, d);
    wr(REG_PSPEED, i + 32'hA);
    wr(REG_PACCEL, i + 32'h100);
    wr(REG_PWAIT, w);
  endtask
  task automatic go;
    @(posedge clock);
    multipos_enable <= 1'b1;
  endtask

  task automatic s_regs;
    do_reset();
    rd_chk(REG_CFG, 32'h1);
    rd_chk(REG_COUNT, 32'h1);
    rd_chk(REG_STATUS, 32'h101);
    rd_chk(REG_PDISP, 32'h2710);
    rd_chk(8'h40, 32'h0);
    wr(REG_COUNT, 32'h0);
    rd_chk(REG_COUNT, 32'h1);
    wr(REG_COUNT, 32'h1F);
    rd_chk(REG_COUNT, 32'h10);
    wr(REG_COUNT, 32'h2);
    wr(REG_RESTART, 32'h5);
    rd_chk(REG_RESTART, 32'h0);
  endtask
  task automatic s_single;
    logic signed [31:0] d [3];
    d = '{32'sh64, -32'sh32, 32'sh7};
    do_reset();
    wr(REG_CFG, 32'h0);
    wr(REG_COUNT, 32'h3);
    for (int i = 0; i < 3; i++) set_prof(i, d[i], 32'h0);
    go();
    for (int i = 0; i < 3; i++) begin
      nxt(i + 1, 200);
      check(unsigned'(move_cmd.delta), {d[i][31], d[i]});
      check(move_cmd.reverse, d[i][31]);
      check(move_cmd.speed, i + 32'hA);
      check(move_cmd.accel, i + 32'h100);
    end
    wait_for(2, 200);
    rd_chk(REG_STATUS, 32'h0001_4003);
  endtask
  task automatic s_cyclic;
    int w;
    for (int u = 0; u < 2; u++) begin
      w = u ? 2000 * TICK : 2 * TICK;
      do_reset();
      wr(REG_CFG, u ? 32'h21 : 32'h1);
      wr(REG_COUNT, 32'h2);
      set_prof(0, 32'h10, 32'h2);
      go();
      nxt(1, 200);
      check(move_cmd.unit_s, u);
      nxt(2, w + 200);
      check(since_done >= w && since_done <= w + 10, 1);
      nxt(1, 200);
    end
  endtask
  // Seconds unit and 5 per profile are set on purpose; both must be ignored
  task automatic s_seq(input logic [4:0] r);
    do_reset();
    wr(REG_CFG, 32'h23);
    wr(REG_COUNT, 32'h3);
    wr(REG_RESTART, r);
    for (int i = 0; i < 3; i++) set_prof(i, 32'h10, 32'h5);
    go();
    for (int k = 0; k < 5; k++) begin
      if (r == 0 && k == 3) break;
      nxt(k < 3 ? k + 1 : k - 1, 200);
      check(move_cmd.unit_s, 0);
      if (k > 0) check(since_done <= 4, 1);
    end
    if (r == 0) wait_for(2, 200);
  endtask
  task automatic s_select;
    logic [3:0] s [3];
    s = '{4'h5, 4'hF, 4'h0};
    do_reset();
    wr(REG_CFG, 32'h22);
    set_prof(5, 32'h10, 32'h5);
    for (int i = 0; i < 3; i++) begin
      @(posedge clock);
      select_bit      <= s[i];
      multipos_enable <= 1'b1;
      nxt(s[i] + 1, 45);
    end
    @(posedge clock);
    mode_switch <= 1'b1;
    select_bit  <= 4'h3;
    wait_for(1, 10);
    repeat (3) @(posedge clock);
    mode_switch <= 1'b0;
    nxt(4, 100);
  endtask
  task automatic s_pause;
    for (int src = 0; src < 3; src++) begin
      do_reset();
      wr(REG_CFG, src == 1 ? 32'h11 : 32'h1);
      wr(REG_COUNT, 32'h4);
      go();
      nxt(1, 200);
      nxt(2, 200);
      @(posedge clock);
      mode_switch     <= src == 0;
      fly_change_en   <= src == 1;
      multipos_enable <= src != 2;
      wait_for(1, 10);
      @(posedge clock);
      mode_switch     <= 1'b0;
      fly_change_en   <= 1'b0;
      multipos_enable <= 1'b1;
      nxt(src == 1 ? 1 : 3, 200);
    end
  endtask
  task automatic s_abs;
    do_reset();
    wr(REG_CFG, 32'h41);
    set_prof(0, 32'h3E8, 32'h0);
    go();
    for (int i = 0; i < 2; i++) begin
      nxt(1, 200);
      check(unsigned'(move_cmd.delta), 33'h3E8 - {motor_pos[31], motor_pos});
    end
  endtask

  initial begin
    arst_n          = 1'b0;
    reg_wr          = 1'b0;
    reg_rd          = 1'b0;
    reg_addr        = 8'h00;
    reg_wdata       = 32'h0;
    select_bit      = 4'h0;
    multipos_enable = 1'b0;
    mode_switch     = 1'b0;
    fly_change_en   = 1'b0;
    lat             = 8'h14;
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    s_regs();
    s_single();
    s_cyclic();
    s_seq(5'h2);
    s_seq(5'h0);
    s_select();
    s_pause();
    s_abs();
    give_verdict();
  end
endmodule
`default_nettype wire
